// ### rtl/tmi_pkg.sv
// Shared constants and types for the temperature interrupt mask and mode block
package tmi_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets on the serial register port
   localparam logic [7:0] TMI_OFS_STAT1 = 8'h01; // First status, held outside
   localparam logic [7:0] TMI_OFS_STAT2 = 8'h02; // Second status, read clears
   localparam logic [7:0] TMI_OFS_MASK1 = 8'h03; // First mask, held outside
   localparam logic [7:0] TMI_OFS_MASK2 = 8'h04; // Second mask and mode bits

   ////////////////////////////////////////////////////////////////////////////
   // Field positions, shared by the second status and second mask registers
   localparam int TMI_BIT_HOT    = 0; // Hot temperature
   localparam int TMI_BIT_BOARD  = 1; // Board temperature alert input
   localparam int TMI_BIT_FIRST_FAN_ALARM   = 2; // First fan alarm
   localparam int TMI_BIT_SECOND_FAN_ALARM   = 3; // Second fan alarm
   localparam int TMI_BIT_CHASS  = 4; // Chassis intrusion
   localparam int TMI_BIT_OVER   = 5; // Overtemperature
   localparam int TMI_BIT_HOTMD  = 6; // Hot source mode select
   localparam int TMI_BIT_OVERMD = 7; // Overtemperature source mode select
   localparam int TMI_NSRC       = 6; // Status sources in the second group

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] TMI_MASK2_RST = 8'h00;
   localparam logic [5:0] TMI_STAT2_RST = 6'h00;
   localparam logic [7:0] TMI_RDATA_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Temperature source arming state
   typedef enum logic [0:0] {
      TMI_COOL = 1'b0, // Last seen below hysteresis (or never hot)
      TMI_HOT  = 1'b1  // Last seen above the hot limit
   } tmi_temp_st_t;

   // State of one temperature source unit
   typedef struct packed {
      tmi_temp_st_t st;   // Arming state
      logic         flag; // Pending status bit
   } tmi_src_s_t;

   // State of the top block
   typedef struct packed {
      logic [7:0]           mask2; // Second mask register
      logic [TMI_NSRC-3:0]  evt;   // Sticky board, fan and chassis bits
      logic [7:0]           rdata; // Read data holding register
      logic                 irq;   // Interrupt output
   } tmi_top_s_t;

endpackage

// ### rtl/tmi_temp_src.sv
`timescale 1ns/1ps
// One temperature status source with default and one-time interrupt modes
module tmi_temp_src
   import tmi_pkg::*;
(
   input  wire logic clk_in,        // System clock
   input  wire logic resetn_in,     // Asynchronous reset, active low
   input  wire logic conv_done_in,  // Conversion finished, one-cycle pulse
   input  wire logic above_in,      // Result above the hot limit
   input  wire logic below_hyst_in, // Result below the hysteresis limit
   input  wire logic one_time_in,   // Mode select: 1 one-time, 0 default
   input  wire logic read_clr_in,   // Status register read, one-cycle pulse
   output logic      flag_out       // Pending status bit
);

   tmi_src_s_t s_q; // Registered state
   tmi_src_s_t s_d; // Next state
   logic       set_w; // Source raises its bit this cycle

   ////////////////////////////////////////////////////////////////////////////
   // Next state: arming follows the conversion result, flag set wins over clear
   always_comb begin
      s_d   = s_q;
      set_w = 1'b0;
      if (conv_done_in) begin
         if (!one_time_in) begin
            // Default mode: any conversion while hot re-raises
            if (above_in) begin
               s_d.st = TMI_HOT; // RL4
            end else if (below_hyst_in) begin
               s_d.st = TMI_COOL; // RL6
            end
            set_w = (s_d.st == TMI_HOT); // RL5 RL6
         end else begin
            case (s_q.st)
               TMI_COOL: begin
                  // Single event on rising through the hot limit
                  if (above_in) begin
                     s_d.st = TMI_HOT;
                     set_w  = 1'b1; // RL7
                  end
               end
               TMI_HOT: begin
                  // Single event on falling through hysteresis
                  if (below_hyst_in) begin
                     s_d.st = TMI_COOL;
                     set_w  = 1'b1; // RL8 RL9
                  end
               end
               default: begin
                  s_d.st = TMI_COOL;
               end
            endcase
         end
      end
      // Read clears; a simultaneous set is kept so no event is lost
      if (read_clr_in) begin
         s_d.flag = 1'b0; // RL5 RL7 RL9 RL10
      end
      if (set_w) begin
         s_d.flag = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_q <= '{st: TMI_COOL, flag: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign flag_out = s_q.flag;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default_rearm_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL5
      (!one_time_in && conv_done_in && s_q.st == TMI_HOT && !below_hyst_in) |=> flag_out)
      else $error("default mode did not re-raise while hot");

   onetime_quiet_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL10
      (one_time_in && conv_done_in && s_q.st == TMI_HOT && !below_hyst_in && !flag_out)
      |=> !flag_out)
      else $error("one-time mode raised again without a crossing");

   onetime_hyst_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL8
      (one_time_in && conv_done_in && s_q.st == TMI_HOT && below_hyst_in)
      |=> (flag_out && s_q.st == TMI_COOL))
      else $error("one-time mode missed the hysteresis crossing");

   read_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL7
      (read_clr_in && !conv_done_in) |=> !flag_out)
      else $error("status read did not clear the flag");

endmodule

// ### rtl/tmi_irq_mask.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RL1) Mask bits 0-5 block matching status from interrupt
// (RL2) Second mask register resets to all zero
// (RL3) Bits 6/7 pick hot/overtemp one-time mode
// (RL4) Default mode raises on conversion above limit
// (RL5) Default mode: read clears, next conversion re-raises
// (RL6) Default mode repeats until below hysteresis
// (RL7) One-time mode: single event rising, read clears
// (RL8) One-time mode: one more event at hysteresis
// (RL9) Hysteresis event cleared by read, then quiet
// (RL10) One-time bit set only by a new crossing
// (RL11) Second status bit layout, upper bits read zero
// (RL12) Temperature sources support only the two modes
// (RL13) Interrupt asserts while enabled and unmasked status pending
module tmi_irq_mask
   import tmi_pkg::*;
(
   input  wire logic       clk_in,                 // System clock, 50 MHz
   input  wire logic       resetn_in,              // Asynchronous reset, active low
   input  wire logic [7:0] reg_addr_in,            // Register index from serial front end
   input  wire logic       reg_wr_in,              // Write strobe, one cycle
   input  wire logic       reg_rd_in,              // Read strobe, one cycle
   input  wire logic [7:0] reg_wdata_in,           // Write data
   output logic      [7:0] reg_rdata_out,          // Read data, valid cycle after strobe
   input  wire logic       conv_done_in,           // Conversion finished, pulse
   input  wire logic       hot_above_in,           // Hot limit exceeded
   input  wire logic       hot_below_hyst_in,      // Below hot hysteresis
   input  wire logic       over_above_in,          // Overtemp limit exceeded
   input  wire logic       over_below_hyst_in,     // Below overtemp hysteresis
   input  wire logic       board_temp_alert_in,    // Board sensor alert event
   input  wire logic       first_fan_alarm_in,     // First fan limit event
   input  wire logic       second_fan_alarm_in,    // Second fan limit event
   input  wire logic       chassis_intrusion_flag_in, // Chassis intrusion event
   input  wire logic [7:0] stat1_in,               // First status group
   input  wire logic [7:0] mask1_in,               // First mask group
   input  wire logic       int_enable_in,          // Global interrupt enable
   output logic            int_out                 // Interrupt request, active high
);

   tmi_top_s_t        s_q;      // Registered state
   tmi_top_s_t        s_d;      // Next state
   logic              rd_stat2; // Read of the second status register
   logic              wr_mask2; // Write of the second mask register
   logic              hot_flag; // Hot temperature status bit
   logic              over_flag; // Overtemperature status bit
   logic [TMI_NSRC-1:0] stat2;  // Assembled second status
   logic [TMI_NSRC-3:0] evt_in; // Incoming board, fan and chassis events
   logic [7:0]          pend1;    // Unmasked first-group status
   logic [TMI_NSRC-1:0] pend2;    // Unmasked second-group status
   logic                any_pend; // Any unmasked status pending

   ////////////////////////////////////////////////////////////////////////////
   // Register decode; strobes last one cycle, so no edge detection is needed
   // and a held strobe would act again on every edge
   assign rd_stat2 = reg_rd_in && (reg_addr_in == TMI_OFS_STAT2);
   assign wr_mask2 = reg_wr_in && (reg_addr_in == TMI_OFS_MASK2);
   assign evt_in   = {chassis_intrusion_flag_in, second_fan_alarm_in,
                      first_fan_alarm_in, board_temp_alert_in};

   ////////////////////////////////////////////////////////////////////////////
   // Temperature sources; only default and one-time modes exist for these
   tmi_temp_src u_hot (                                  // RL12
      .clk_in        (clk_in),
      .resetn_in     (resetn_in),
      .conv_done_in  (conv_done_in),
      .above_in      (hot_above_in),
      .below_hyst_in (hot_below_hyst_in),
      .one_time_in   (s_q.mask2[TMI_BIT_HOTMD]),
      .read_clr_in   (rd_stat2),
      .flag_out      (hot_flag)
   );

   tmi_temp_src u_over (
      .clk_in        (clk_in),
      .resetn_in     (resetn_in),
      .conv_done_in  (conv_done_in),
      .above_in      (over_above_in),
      .below_hyst_in (over_below_hyst_in),
      .one_time_in   (s_q.mask2[TMI_BIT_OVERMD]),
      .read_clr_in   (rd_stat2),
      .flag_out      (over_flag)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Status layout: hot, board, first_fan_alarm, second_fan_alarm, chassis, overtemp
   // Upper two bits are reserved and read back as zero
   assign stat2 = {over_flag, s_q.evt, hot_flag}; // RL11

   ////////////////////////////////////////////////////////////////////////////
   // Pending terms; mask bits gate the interrupt only, the status bits
   // themselves still set and read back while masked
   assign pend1    = stat1_in & ~mask1_in; // RL13
   assign pend2    = stat2 & ~s_q.mask2[TMI_NSRC-1:0]; // RL1
   assign any_pend = (|pend1) || (|pend2);

   ////////////////////////////////////////////////////////////////////////////
   // Next state: register access, sticky events, interrupt combine
   always_comb begin
      // Hold everything unless a branch below changes it
      s_d = s_q;
      // Mask and mode bits are plain storage
      if (wr_mask2) begin
         s_d.mask2 = reg_wdata_in; // RL3
      end
      // Writes to any other index are dropped; status is read-only
      // Read data is captured before the read clears anything, and indices
      // 01 and 03 simply mirror the registers held outside this block
      if (reg_rd_in) begin
         case (reg_addr_in)
            TMI_OFS_STAT1: s_d.rdata = stat1_in;
            TMI_OFS_STAT2: s_d.rdata = {2'h0, stat2}; // RL11
            TMI_OFS_MASK1: s_d.rdata = mask1_in;
            TMI_OFS_MASK2: s_d.rdata = s_q.mask2;
            default:       s_d.rdata = 8'h00;
         endcase
      end
      // Sticky events; an event in the read cycle survives the clear
      // Events are levels seen on any edge; a one-cycle pulse is enough
      if (rd_stat2) begin
         s_d.evt = '0;
      end
      s_d.evt = s_d.evt | evt_in;
      // Registered interrupt, one cycle behind the status it reflects; the
      // flip-flop keeps the pin free of glitches while status bits settle
      s_d.irq = int_enable_in && any_pend; // RL1 RL13
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; the asynchronous clear gives the power-on values, and
   // the reset branch loads constants only
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_q <= '{mask2: TMI_MASK2_RST, evt: '0, rdata: TMI_RDATA_RST, irq: 1'b0}; // RL2
      end else begin
         s_q <= s_d;
      end
   end

   // Both outputs come straight from flip-flops
   assign reg_rdata_out = s_q.rdata; // Stands until the next read
   assign int_out       = s_q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   mask_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL3
      wr_mask2 |=> (s_q.mask2 == $past(reg_wdata_in)))
      else $error("mask write not stored");

   irq_follows_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL13
      (int_enable_in && (|(stat2 & ~s_q.mask2[TMI_NSRC-1:0]))) |=> int_out)
      else $error("interrupt missing for unmasked status");

   irq_masked_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL1
      (!int_enable_in || ((stat1_in & ~mask1_in) == 8'h00 &&
       (stat2 & ~s_q.mask2[TMI_NSRC-1:0]) == 6'h00)) |=> !int_out)
      else $error("interrupt raised with all status masked");

   stat_upper_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL11
      rd_stat2 |=> (reg_rdata_out[7:6] == 2'h0 && reg_rdata_out[5:0] == $past(stat2)))
      else $error("second status read returned wrong bits");

   evt_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL11
      (rd_stat2 && !first_fan_alarm_in) |=> !stat2[TMI_BIT_FIRST_FAN_ALARM])
      else $error("fan bit not cleared by status read");

   ////////////////////////////////////////////////////////////////////////////
   // Reset, storage and read-back checks
   reset_clean_a: assert property (@(posedge clk_in) // RL2
      $rose(resetn_in) |-> (s_q.mask2 == TMI_MASK2_RST && s_q.evt == '0 &&
                            !int_out && reg_rdata_out == TMI_RDATA_RST))
      else $error("block left reset with non-zero state");

   mask_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL3
      !wr_mask2 |=> (s_q.mask2 == $past(s_q.mask2)))
      else $error("mask register changed without a write");

   mask_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL3
      (reg_rd_in && reg_addr_in == TMI_OFS_MASK2) |=> (reg_rdata_out == $past(s_q.mask2)))
      else $error("mask register read back wrong");

   stat1_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL13
      (reg_rd_in && reg_addr_in == TMI_OFS_STAT1) |=> (reg_rdata_out == $past(stat1_in)))
      else $error("first status read back wrong");

   mask1_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL13
      (reg_rd_in && reg_addr_in == TMI_OFS_MASK1) |=> (reg_rdata_out == $past(mask1_in)))
      else $error("first mask read back wrong");

   unmapped_zero_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL11
      (reg_rd_in && (reg_addr_in < TMI_OFS_STAT1 || reg_addr_in > TMI_OFS_MASK2))
      |=> (reg_rdata_out == 8'h00))
      else $error("unmapped register read not zero");

   ////////////////////////////////////////////////////////////////////////////
   // Sticky event and read-data checks
   evt_sticky_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL11
      (|evt_in) |=> ((s_q.evt & $past(evt_in)) == $past(evt_in)))
      else $error("board, fan or chassis event not latched");

   evt_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL11
      !rd_stat2 |=> ((s_q.evt & $past(s_q.evt)) == $past(s_q.evt)))
      else $error("event bit lost without a status read");

   rdata_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL11
      !reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data changed without a read");

   ////////////////////////////////////////////////////////////////////////////
   // Status and interrupt checks, seen from the top
   stat_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL10
      (rd_stat2 && !conv_done_in && evt_in == '0) |=> (stat2 == '0))
      else $error("status read left a bit set");

   stat_hot_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL4
      (conv_done_in && hot_above_in && !s_q.mask2[TMI_BIT_HOTMD]) |=> stat2[TMI_BIT_HOT])
      else $error("hot conversion did not set its status bit");

   stat_over_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL4
      (conv_done_in && over_above_in && !s_q.mask2[TMI_BIT_OVERMD]) |=> stat2[TMI_BIT_OVER])
      else $error("overtemperature conversion did not set its status bit");

   irq_off_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RL13
      !int_enable_in |=> !int_out)
      else $error("interrupt raised while globally disabled");

endmodule

// ### test/tmi_host_model.sv
`timescale 1ns/1ps
// Register master standing in for the serial front end
module tmi_host_model (
   input  wire logic       clk_in,    // System clock
   input  wire logic [7:0] rdata_in,  // Read data from the block
   output logic      [7:0] addr_out,  // Register index
   output logic            wr_out,    // Write strobe
   output logic            rd_out,    // Read strobe
   output logic      [7:0] wdata_out  // Write data
);
   ////////////////////////////////////////////////////////////////////////////
   // Idle bus at time zero
   initial begin
      addr_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
      wdata_out = 8'h00;
   end

   // One-cycle write; index scrambled after so a stale value cannot match
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask

   // One-cycle read; data settles at the taking edge and is sampled one edge later
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      @(posedge clk_in);
      #1 d = rdata_in;
   endtask
endmodule

// ### test/tmi_irq_mask_test.sv
`timescale 1ns/1ps
// Random register, conversion and event traffic against a queue-free model
module tmi_irq_mask_test;
   import tmi_pkg::*;
   logic       clk_in, resetn_in, conv, hot_a, hot_b, ov_a, ov_b, en, int_o, wr, rd;
   logic [3:0] evt;                // Board, fan, fan, chassis events
   logic [7:0] stat1, mask1, addr, wdata, rdata, got;
   int         failures, cmp_count;
   int         m_mask, m_stat, hot_st, ov_st; // Reference state
   logic [31:0] seed, r, d;

   tmi_irq_mask tmi_irq_mask_i (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .conv_done_in(conv), .hot_above_in(hot_a), .hot_below_hyst_in(hot_b),
      .over_above_in(ov_a), .over_below_hyst_in(ov_b), .board_temp_alert_in(evt[0]),
      .first_fan_alarm_in(evt[1]), .second_fan_alarm_in(evt[2]),
      .chassis_intrusion_flag_in(evt[3]), .stat1_in(stat1), .mask1_in(mask1),
      .int_enable_in(en), .int_out(int_o));
   tmi_host_model tmi_host_model_i (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
      .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [7:0] g, input int e);
      cmp_count++;
      if (g !== e[7:0]) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e[7:0]);
      end
   endtask

   // Default mode sets on every conversion while hot, including between the
   // limits; one-time mode sets only on crossings
   task automatic src_upd(input int ab, be, ot, b, inout int st);
      if (ot == 0) begin
         if (ab) st = 1;
         else if (be) st = 0;
         if (st == 1) m_stat |= 1 << b;
      end else if (st == 0 && ab) begin
         st = 1;
         m_stat |= 1 << b;
      end else if (st == 1 && be) begin
         st = 0;
         m_stat |= 1 << b;
      end
   endtask

   task automatic convert(input logic [3:0] v);
      @(posedge clk_in);
      conv <= 1'b1;
      {ov_b, ov_a, hot_b, hot_a} <= v;
      @(posedge clk_in);
      conv <= 1'b0;
      src_upd(v[0], v[1], m_mask[6], 0, hot_st);
      src_upd(v[2], v[3], m_mask[7], 5, ov_st);
   endtask

   task automatic conclude();
      if (failures == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   initial begin
      #500000;
      failures++;
      conclude();
   end

   // Main sequence: reset, reset values, then 400 random operations
   initial begin
      {resetn_in, conv, hot_a, hot_b, ov_a, ov_b, en, evt} = '0;
      {stat1, mask1} = '0;
      {failures, cmp_count, m_mask, m_stat, hot_st, ov_st} = '0;
      seed = 32'h00fd7a62;
      repeat (6) @(posedge clk_in);
      resetn_in <= 1'b1;
      tmi_host_model_i.rd_reg(TMI_OFS_MASK2, got);
      check(got, 0);
      tmi_host_model_i.rd_reg(TMI_OFS_STAT2, got);
      check(got, 0);
      for (int i = 0; i < 400; i++) begin
         r = rnd();
         d = rnd();
         @(posedge clk_in);
         en <= r[8] | r[9];
         stat1 <= r[23:16] & {8{r[10] & r[11]}};
         mask1 <= r[31:24];
         case (r[2:0])
            3'd0: begin
               tmi_host_model_i.wr_reg(TMI_OFS_MASK2, d[7:0]);
               m_mask = d[7:0];
            end
            3'd1: tmi_host_model_i.wr_reg(r[12] ? TMI_OFS_STAT2 : TMI_OFS_MASK1, d[7:0]);
            3'd2: begin
               tmi_host_model_i.rd_reg(TMI_OFS_STAT2, got);
               check(got, m_stat);
               m_stat = 0;
            end
            3'd3: begin
               tmi_host_model_i.rd_reg(TMI_OFS_MASK2, got);
               check(got, m_mask);
            end
            3'd4: begin
               d[7:0] = r[13] ? TMI_OFS_STAT1 : r[14] ? TMI_OFS_MASK1 : {3'b001, d[4:0]};
               tmi_host_model_i.rd_reg(d[7:0], got);
               check(got, d[7:0] == TMI_OFS_STAT1 ? stat1 : d[7:0] == TMI_OFS_MASK1 ? mask1 : 0);
            end
            3'd5: begin
               @(posedge clk_in);
               evt[d[1:0]] <= 1'b1;
               @(posedge clk_in);
               evt <= 4'h0;
               m_stat |= 1 << (d[1:0] + 1);
            end
            default: convert({~d[2] & d[3], d[2], ~d[0] & d[1], d[0]});
         endcase
         repeat (2) @(posedge clk_in);
         #1 check({7'h00, int_o}, en & ((|(stat1 & ~mask1)) | (|(m_stat & ~m_mask & 63))));
      end
      conclude();
   end
endmodule
